//--- shared/gplc_map.vh
// Register layout and constants for the general pin configuration unit
`ifndef GPLC_MAP_VH
`define GPLC_MAP_VH
`define GPLC_CFG_OFFSET 8'h88
`define GPLC_LAMP_LSB 28
`define GPLC_POL_LSB 24
`define GPLC_EEF_LSB 20
`define GPLC_BUF_LSB 16
`define GPLC_DIR_LSB 8
`define GPLC_OOD_LSB 3
`define GPLC_PIN_LSB 0
`define GPLC_LAMP_RST 3'h0
`define GPLC_POL_RST 3'h0
`define GPLC_EEF_RST 3'h0
`define GPLC_BUF_RST 3'h0
`define GPLC_DIR_RST 3'h0
`define GPLC_OOD_RST 2'h0
`define GPLC_PIN_RST 3'h0
`define GPLC_EEF_EEPROM 3'h0
`define GPLC_EEF_O3_O4 3'h1
`define GPLC_EEF_O3_RXDV 3'h3
`define GPLC_EEF_TXEN_O4 3'h5
`define GPLC_EEF_TXEN_RXDV 3'h6
`define GPLC_EEF_CLKS 3'h7
`endif

//--- hdl/gplc_pin_cell.v
// One general pin: driver control, input sampling, event level
`timescale 1ns/1ps
`default_nettype none
module gplc_pin_cell (
  input wire clk_i,
  input wire rst_n_i,
  input wire pin_in_i,
  input wire pin_data_i,
  input wire pin_direction_i,
  input wire pin_buffer_type_i,
  input wire status_lamp_select_i,
  input wire lamp_level_i,
  input wire pin_event_polarity_i,
  output reg pin_out_o,
  output reg pin_oe_o,
  output reg pin_level_o,
  output reg pin_event_o
);
  reg drive_en;
  reg drive_val;
  reg nxt_oe;

  // Lamp use overrides the general pin function
  always @* begin
    drive_en = status_lamp_select_i | pin_direction_i;
    drive_val = status_lamp_select_i ? lamp_level_i : pin_data_i;
    // Open-drain only pulls low; a high is left to the pull-up
    if (!drive_en) begin
      nxt_oe = 1'b0;
    end else if (pin_buffer_type_i) begin
      nxt_oe = 1'b1;
    end else begin
      nxt_oe = ~drive_val;
    end
  end

  // Registered so every pin output comes from a flip-flop
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o <= 1'b0;
      pin_oe_o <= 1'b0;
      pin_level_o <= 1'b0;
      pin_event_o <= 1'b0;
    end else begin
      pin_out_o <= drive_val;
      pin_oe_o <= nxt_oe;
      pin_level_o <= pin_in_i;
      pin_event_o <= ~(pin_in_i ^ pin_event_polarity_i);
    end
  end
endmodule
`default_nettype wire

//--- hdl/gplc_top.v
// General pin configuration register, pin cells and EEPROM pin mux
`timescale 1ns/1ps
`default_nettype none
`include "gplc_map.vh"
// What this block does
// - Three-bit EEPROM pin function field, reset zero, picks what both EEPROM pins carry
// - Codes map to EEPROM, outputs three/four, TX_EN, RX_DV, TX_CLK, RX_CLK
// - RX_DV and clocks come from internal PHY, TX_EN from MAC
// - Buffer type bit one gives push/pull, zero gives open-drain
// - Direction bit one makes the pin an output, zero an input
// - Bits 3 and 4 drive general outputs three and four, reset zero
// - Output pin drives the last written data bit
// - Reading a pin data bit returns the sampled pin level
// - Lamp select bits make pins act as status lamp outputs
// - Polarity bit picks the level that raises the pin event
module gplc_top #(
  parameter NPINS = 3
) (
  input wire clk_i,
  input wire rst_n_i,
  // Host register port, one-cycle strobes
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // General pins
  input wire [NPINS-1:0] gpio_in_i,
  output wire [NPINS-1:0] gpio_out_o,
  output wire [NPINS-1:0] gpio_oe_o,
  input wire [NPINS-1:0] lamp_level_i,
  output wire [NPINS-1:0] pin_event_o,
  // EEPROM controller side
  input wire ee_data_out_i,
  input wire ee_data_oe_i,
  output reg ee_data_in_o,
  input wire ee_clk_i,
  // Monitor sources
  input wire int_phy_rx_dv_i,
  input wire int_phy_tx_clk_i,
  input wire int_phy_rx_clk_i,
  input wire mac_tx_en_i,
  // EEPROM pins
  input wire eeprom_serial_data_pin_i,
  output reg eeprom_serial_data_pin_o,
  output reg eeprom_serial_data_pin_oe_o,
  output reg eeprom_serial_clock_pin_o
);
  reg [2:0] status_lamp_select_ff;
  reg [2:0] pin_event_polarity_ff;
  reg [2:0] eeprom_pin_function_select_ff;
  reg [2:0] pin_buffer_type_ff;
  reg [2:0] pin_direction_ff;
  reg [1:0] output_only_data_ff;
  reg [2:0] pin_data_ff;
  wire [NPINS-1:0] pin_level;
  wire cfg_hit;
  reg [31:0] rd_word;
  reg nxt_dio;
  reg nxt_dio_oe;
  reg nxt_clk;
  wire cfg_wr;
  wire cfg_rd;
  wire [2:0] wr_lamp;
  wire [2:0] wr_pol;
  wire [2:0] wr_eef;
  wire [2:0] wr_buf;
  wire [2:0] wr_dir;
  wire [1:0] wr_ood;
  wire [2:0] wr_pin;

  // Address decode; only the configuration word is mapped
  assign cfg_hit = (reg_addr_i == `GPLC_CFG_OFFSET);
  assign cfg_wr = reg_wr_i & cfg_hit;
  assign cfg_rd = reg_rd_i & cfg_hit;

  // Field views of the write word
  assign wr_lamp = reg_wdata_i[`GPLC_LAMP_LSB+2:`GPLC_LAMP_LSB];
  assign wr_pol = reg_wdata_i[`GPLC_POL_LSB+2:`GPLC_POL_LSB];
  assign wr_eef = reg_wdata_i[`GPLC_EEF_LSB+2:`GPLC_EEF_LSB];
  assign wr_buf = reg_wdata_i[`GPLC_BUF_LSB+2:`GPLC_BUF_LSB];
  assign wr_dir = reg_wdata_i[`GPLC_DIR_LSB+2:`GPLC_DIR_LSB];
  assign wr_ood = reg_wdata_i[`GPLC_OOD_LSB+1:`GPLC_OOD_LSB];
  assign wr_pin = reg_wdata_i[`GPLC_PIN_LSB+2:`GPLC_PIN_LSB];

  // Configuration register; software writes whole word
  // Writes to other addresses leave every field alone
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_lamp_select_ff <= `GPLC_LAMP_RST;
      pin_event_polarity_ff <= `GPLC_POL_RST;
      eeprom_pin_function_select_ff <= `GPLC_EEF_RST;
      pin_buffer_type_ff <= `GPLC_BUF_RST;
      pin_direction_ff <= `GPLC_DIR_RST;
      output_only_data_ff <= `GPLC_OOD_RST;
      pin_data_ff <= `GPLC_PIN_RST;
    end else if (cfg_wr) begin
      status_lamp_select_ff <= wr_lamp;
      pin_event_polarity_ff <= wr_pol;
      // Reserved codes and mid-cycle changes are left to software
      eeprom_pin_function_select_ff <= wr_eef;
      pin_buffer_type_ff <= wr_buf;
      pin_direction_ff <= wr_dir;
      output_only_data_ff <= wr_ood;
      pin_data_ff <= wr_pin;
    end
  end

  // One cell per general pin
  // Lamp select overrides direction inside each cell
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
      gplc_pin_cell u_cell (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_in_i(gpio_in_i[gi]),
        .pin_data_i(pin_data_ff[gi]),
        .pin_direction_i(pin_direction_ff[gi]),
        .pin_buffer_type_i(pin_buffer_type_ff[gi]),
        .status_lamp_select_i(status_lamp_select_ff[gi]),
        .lamp_level_i(lamp_level_i[gi]),
        .pin_event_polarity_i(pin_event_polarity_ff[gi]),
        .pin_out_o(gpio_out_o[gi]),
        .pin_oe_o(gpio_oe_o[gi]),
        .pin_level_o(pin_level[gi]),
        .pin_event_o(pin_event_o[gi])
      );
    end
  endgenerate

  // Read word; data bits show pin level, not stored value
  always @* begin
    // Spare bits stay zero
    rd_word = 32'h0;
    rd_word[`GPLC_LAMP_LSB+2:`GPLC_LAMP_LSB] = status_lamp_select_ff;
    rd_word[`GPLC_POL_LSB+2:`GPLC_POL_LSB] = pin_event_polarity_ff;
    rd_word[`GPLC_EEF_LSB+2:`GPLC_EEF_LSB] = eeprom_pin_function_select_ff;
    rd_word[`GPLC_BUF_LSB+2:`GPLC_BUF_LSB] = pin_buffer_type_ff;
    rd_word[`GPLC_DIR_LSB+2:`GPLC_DIR_LSB] = pin_direction_ff;
    rd_word[`GPLC_OOD_LSB+1:`GPLC_OOD_LSB] = output_only_data_ff;
    rd_word[`GPLC_PIN_LSB+2:`GPLC_PIN_LSB] = pin_level[2:0];
  end

  // Read answer one cycle after the strobe; unmapped reads give zero
  // Data holds between reads so the host may fetch it late
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= cfg_rd ? rd_word : 32'h0;
      end
    end
  end

  // EEPROM pin mux; monitor sources are fixed whatever PHY is in use
  always @* begin
    // Defaults: data pin driven, both levels low
    nxt_dio = 1'b0;
    nxt_dio_oe = 1'b1;
    nxt_clk = 1'b0;
    case (eeprom_pin_function_select_ff)
      `GPLC_EEF_EEPROM: begin
        // Controller owns both pins and the data direction
        nxt_dio = ee_data_out_i;
        nxt_dio_oe = ee_data_oe_i;
        nxt_clk = ee_clk_i;
      end
      `GPLC_EEF_O3_O4: begin
        // Both pins become plain general outputs
        nxt_dio = output_only_data_ff[0];
        nxt_clk = output_only_data_ff[1];
      end
      `GPLC_EEF_O3_RXDV: begin
        // Output three with receive-valid monitor
        nxt_dio = output_only_data_ff[0];
        nxt_clk = int_phy_rx_dv_i;
      end
      `GPLC_EEF_TXEN_O4: begin
        // Transmit-enable monitor with output four
        nxt_dio = mac_tx_en_i;
        nxt_clk = output_only_data_ff[1];
      end
      `GPLC_EEF_TXEN_RXDV: begin
        // Both frame-qualifier monitors
        nxt_dio = mac_tx_en_i;
        nxt_clk = int_phy_rx_dv_i;
      end
      `GPLC_EEF_CLKS: begin
        // Both link clock monitors, sampled at the device clock
        nxt_dio = int_phy_tx_clk_i;
        nxt_clk = int_phy_rx_clk_i;
      end
      default: begin
        // Reserved codes park the data pin undriven
        nxt_dio_oe = 1'b0;
      end
    endcase
  end

  // Registered pin drive; clock monitors therefore carry one cycle of lag
  // Data pin level is copied back for the EEPROM controller
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eeprom_serial_data_pin_o <= 1'b0;
      eeprom_serial_data_pin_oe_o <= 1'b0;
      eeprom_serial_clock_pin_o <= 1'b0;
      ee_data_in_o <= 1'b0;
    end else begin
      eeprom_serial_data_pin_o <= nxt_dio;
      eeprom_serial_data_pin_oe_o <= nxt_dio_oe;
      eeprom_serial_clock_pin_o <= nxt_clk;
      ee_data_in_o <= eeprom_serial_data_pin_i;
    end
  end
endmodule
`default_nettype wire

//--- testbench/gplc_monitor.sv
// Port assertions for the pin configuration unit
`timescale 1ns/1ps
`default_nettype none
module gplc_monitor #(
  parameter NPINS = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [NPINS-1:0] gpio_in_i,
  input wire logic [NPINS-1:0] gpio_oe_o,
  input wire logic [NPINS-1:0] lamp_level_i,
  input wire logic [NPINS-1:0] pin_event_o,
  input wire logic ee_data_oe_i,
  input wire logic eeprom_serial_data_pin_i,
  input wire logic ee_data_in_o,
  input wire logic eeprom_serial_data_pin_oe_o
);
  reg [1:0] live_ff;
  reg [NPINS-1:0] in_d_ff;
  wire [NPINS-1:0] ev_x = pin_event_o ^ in_d_ff;
  // Two edges of history before trusting $past
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      live_ff <= 2'h0;
    end else begin
      live_ff <= {live_ff[0], 1'b1};
    end
  end
  // Input as the pin cells saw it
  always @(posedge clk_i) begin
    in_d_ff <= gpio_in_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  read_answer_a: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer late");
  stray_read_a: assert property (reg_rvalid_o && $past(reg_addr_i) != 8'h88 |-> reg_rdata_o == 32'h0)
    else $error("stray read not zero");
  rdata_hold_a: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved");
  spare_bits_a: assert property (reg_rvalid_o |-> (reg_rdata_o & 32'h8888f8e0) == 32'h0)
    else $error("spare bits set");
  data_copy_a: assert property (live_ff[1] |-> ee_data_in_o == $past(eeprom_serial_data_pin_i))
    else $error("data pin copy wrong");
  data_enable_a: assert property (live_ff[1] && $past(ee_data_oe_i) |-> eeprom_serial_data_pin_oe_o)
    else $error("data pin not driven");
  drive_cause_a: assert property (live_ff[1] && $changed(gpio_oe_o) |->
    $past(reg_wr_i, 2) || $past(lamp_level_i) != $past(lamp_level_i, 2))
    else $error("pin enable moved alone");
  event_follow_a: assert property (live_ff[1] |-> $stable(ev_x) || $past(reg_wr_i, 2))
    else $error("event lost its input");
endmodule
bind gplc_top gplc_monitor #(.NPINS(NPINS)) i_mon (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .gpio_in_i(gpio_in_i),
  .gpio_oe_o(gpio_oe_o),
  .lamp_level_i(lamp_level_i),
  .pin_event_o(pin_event_o),
  .ee_data_oe_i(ee_data_oe_i),
  .eeprom_serial_data_pin_i(eeprom_serial_data_pin_i),
  .ee_data_in_o(ee_data_in_o),
  .eeprom_serial_data_pin_oe_o(eeprom_serial_data_pin_oe_o)
);
`default_nettype wire

//--- testbench/testbench.sv
// Random bench for the pin configuration unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam [17:0] codes = 18'h3eac8;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg [31:0] reg_wdata_i = 32'h0;
  reg [13:0] src = 14'h0;
  reg [31:0] w, r, q;
  integer k, errors, n_checks;
  wire [31:0] reg_rdata_o;
  wire [2:0] gpio_out_o, gpio_oe_o, pin_event_o;
  wire reg_rvalid_o, ee_data_in_o, ee_d_o, ee_oe_o, ee_c_o;
  gplc_top i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .gpio_in_i(src[13:11]), .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o),
    .lamp_level_i(src[10:8]), .pin_event_o(pin_event_o),
    .ee_data_out_i(src[7]), .ee_data_oe_i(src[6]), .ee_data_in_o(ee_data_in_o), .ee_clk_i(src[5]),
    .int_phy_rx_dv_i(src[4]), .int_phy_tx_clk_i(src[3]), .int_phy_rx_clk_i(src[2]),
    .mac_tx_en_i(src[1]), .eeprom_serial_data_pin_i(src[0]),
    .eeprom_serial_data_pin_o(ee_d_o), .eeprom_serial_data_pin_oe_o(ee_oe_o),
    .eeprom_serial_clock_pin_o(ee_c_o)
  );
  // Pin enable and driven value per pin
  function [5:0] pins(input [31:0] c, input [2:0] lv);
    reg [2:0] v;
    begin
      v = (c[30:28] & lv) | (~c[30:28] & c[2:0]);
      pins[5:3] = (c[30:28] | c[10:8]) & (c[18:16] | ~v);
      pins[2:0] = v;
    end
  endfunction
  // Data, enable and clock seen on the serial memory pins
  function [2:0] eef(input [31:0] c, input [13:0] s);
    case (c[22:20])
      3'h0: eef = s[7:5];
      3'h1: eef = {c[3], 1'b1, c[4]};
      3'h3: eef = {c[3], 1'b1, s[4]};
      3'h5: eef = {s[1], 1'b1, c[4]};
      3'h6: eef = {s[1], 1'b1, s[4]};
      default: eef = {s[3], 1'b1, s[2]};
    endcase
  endfunction
  // Write strobe stays up until the next task takes the bus
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      reg_wr_i <= 1'b0;
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(posedge clk_i);
      d = reg_rdata_o;
      chk("read valid", 32'h1, {31'h0, reg_rvalid_o});
    end
  endtask
  task chk(input [127:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Hang guard, far beyond the expected eighty-odd cycles
  initial begin
    #4000;
    errors = errors + 1;
    end_sim;
  end
  // Every legal pin function code twice, random fields around it
  // Controller pins hold still per pass, so no EEPROM cycle spans a field change
  initial begin
    errors = 0;
    n_checks = 0;
    r = $urandom(21190);
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(8'h88, q);
    chk("reset word", 32'h0, q);
    for (k = 0; k < 12; k = k + 1) begin
      r = $urandom;
      w = $urandom & 32'h7777071f;
      w[22:20] = codes[3*(k%6) +: 3];
      src <= r[13:0];
      wr(8'h88, w);
      wr(8'h8c, ~w);
      rd(8'h88, q);
      chk("config word", (w & 32'h77770718) | r[13:11], q);
      chk("pin drive", pins(w, r[10:8]), {gpio_oe_o, gpio_out_o});
      chk("eeprom pins", eef(w, r[13:0]), {ee_d_o, ee_oe_o, ee_c_o});
      chk("data copy", {31'h0, r[0]}, {31'h0, ee_data_in_o});
      chk("pin event", 3'h7 & ~(r[13:11] ^ w[26:24]), pin_event_o);
      rd(8'ha0, q);
      chk("stray read", 32'h0, q);
    end
    // Reset in mid-run returns every field to zero
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(8'h88, q);
    chk("reset again", {29'h0, src[13:11]}, q);
    chk("reset pins", 32'h0, {gpio_oe_o, gpio_out_o});
    chk("reset eeprom", eef(32'h0, src), {ee_d_o, ee_oe_o, ee_c_o});
    end_sim;
  end
endmodule
`default_nettype wire
